// ### hw/usb_ep0_defines.svh
// Purpose: register map, field positions and reset values of the EP0 block
// Assumes: included by bare name wherever the map is needed
// Notes: byte addresses, one aligned 32-bit word per register
// Functional notes
// - Host bus reset clears logic when enabled
// - Control writes blocked during enabled bus reset
// - Firmware sets stall; next setup clears it
// - Stall clear waits for config access end
// - Setup accepted in idle sets flag and raises interrupt if unmasked
// - Setup flag set forces NAK on IN
// - Flag clear never starts an unasked transmit
// - Enable bit clear resets module and transmit
// - Zero power control disables regulators
// - Read-only bus power valid status bit
`ifndef USB_EP0_DEFINES_SVH
`define USB_EP0_DEFINES_SVH

// Register byte offsets
`define A_CTRL      6'h00
`define A_PWR       6'h04
`define A_PLL_FLAG  6'h08
`define A_INT_STAT  6'h0c
`define A_INT_MASK  6'h10
`define A_IN_CFG    6'h14
`define A_OUT_CFG   6'h18
`define A_STATUS    6'h1c

// Control register fields
`define CTRL_EN     0
`define CTRL_FRST   1
`define CTRL_PLLEN  2
`define CTRL_RST    3'h0

// Power control, two regulator enables
`define PWR_RST     2'h0

// Interrupt status and mask fields
`define INT_BUSRST  0
`define INT_SUSP    1
`define INT_SETUP   2
`define INT_IN0     3
`define INT_OUT0    4

// PLL flag fields
`define PLL_UNLOCK  0
`define PLL_LOST    1

// Endpoint 0 configuration fields
`define CFG_EN      0
`define CFG_STALL   1
`define CFG_NAK     2
`define CFG_RST     3'h0

`endif

// ### hw/usb_ep0_pkg.sv
// Purpose: shared types of the EP0 control block
// Assumes: used by scoped name only
// Notes: link state codes are one-hot
package usb_ep0_pkg;

  // Token kinds from the serial engine
  typedef enum logic [1:0] {
    TOK_SETUP = 2'h0,
    TOK_IN    = 2'h1,
    TOK_OUT   = 2'h2
  } tok_kind_t;

  // Handshake answers
  typedef enum logic [1:0] {
    HS_ACK   = 2'h0,
    HS_NAK   = 2'h1,
    HS_STALL = 2'h2
  } hs_t;

  // Link states
  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,
    ST_RESET = 4'h2,
    ST_IDLE  = 4'h4,
    ST_TX    = 4'h8
  } link_state_t;

endpackage

// ### hw/sticky_flags.sv
// Purpose: bank of sticky flags set by hardware, cleared by a clear vector
// Assumes: one clock, synchronous active-low reset
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);

  logic [W-1:0] flag_q;  // Flag state

  // One flip-flop per flag
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          flag_q[i] <= 1'b0;
        end else if (set[i]) begin
          flag_q[i] <= 1'b1;  // Event never lost to a clear
        end else if (clr[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flags = flag_q;

endmodule

// ### hw/ep0_cfg.sv
// Purpose: one endpoint 0 configuration register with held stall clear
// Assumes: busy is high for every cycle of a bus access to this register
// Notes: a setup seen during an access is remembered until it ends
`timescale 1ns/1ps
`include "usb_ep0_defines.svh"
module ep0_cfg (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       wr,
  input  wire logic [2:0] wdata,
  input  wire logic       busy,
  input  wire logic       setup,
  output logic      [2:0] cfg
);

  logic [2:0] cfg_q;   // Enable, stall, NAK
  logic       pend_q;  // Stall clear waiting for access end

  // Register contents
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      cfg_q <= `CFG_RST;
    end else if (wr) begin
      cfg_q <= wdata;
    end else if ((setup || pend_q) && !busy) begin
      cfg_q[`CFG_STALL] <= 1'b0;
    end
  end

  // Remember a setup that arrived mid-access
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      pend_q <= 1'b0;
    end else if (setup && busy) begin
      pend_q <= 1'b1;
    end else if (!busy) begin
      pend_q <= 1'b0;
    end
  end

  assign cfg = cfg_q;

endmodule

// ### hw/usb_ep0_ctrl.sv
// Purpose: EP0 control transfer and bus reset logic with Avalon-MM registers
// Assumes: token strobes are synchronous to clk, one cycle each
// Notes: every bus access takes exactly one wait cycle
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "usb_ep0_defines.svh"
module usb_ep0_ctrl (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Avalon-MM slave
  input  wire logic [5:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  output logic                         irq,
  // Link side, from the serial engine
  input  wire logic                    bus_reset,
  input  wire logic                    suspend_req,
  input  wire logic                    tok_valid,
  input  usb_ep0_pkg::tok_kind_t       tok_kind,
  input  wire logic                    tok_ep0,
  input  wire logic                    tx_done,
  output logic                         hs_valid,
  output usb_ep0_pkg::hs_t             hs_code,
  output logic                         tx_start,
  output logic                         tx_busy,
  // Analogue side
  input  wire logic                    vbus_present,
  input  wire logic                    pll_locked,
  output logic                         pll_en,
  output logic      [1:0]              ldo_en
);

  // Decode of the registers that bus reset may lock
  function automatic logic lockable(input logic [5:0] a);
    lockable = (a == `A_CTRL) || (a == `A_IN_CFG) || (a == `A_OUT_CFG);
  endfunction

  // Bus slave state
  logic        wait_q;       // Waitrequest, high between accesses
  logic [31:0] rdata_q;      // Read data register
  logic        req;          // A request is on the bus
  logic        commit;       // Edge at which the access completes
  logic        wr_ok;        // Write takes effect this edge
  logic        lock;         // Control writes blocked

  // Software registers
  logic [2:0]  ctrl_q;       // Enable, reset connect, PLL enable
  logic [1:0]  pwr_q;        // Regulator enables
  logic [4:0]  mask_q;       // Interrupt mask
  logic        irq_q;        // Interrupt output
  logic        vbus_ok_q;    // Bus power valid status

  // Link state
  usb_ep0_pkg::link_state_t state_q;
  usb_ep0_pkg::link_state_t state_d;
  logic        bus_reset_q;  // Previous bus reset level
  logic        locked_q;     // Previous PLL lock level
  logic        soft_rst;     // Module-level reset of link logic
  logic        hs_valid_q;   // Handshake strobe
  usb_ep0_pkg::hs_t hs_code_q;
  logic        tx_start_q;   // Data transmit strobe
  logic        tok;          // EP0 token accepted this cycle
  logic        setup_evt;    // Setup token accepted
  logic        out_ack;      // OUT token acknowledged

  // Flag banks and endpoint configuration
  logic [4:0]  int_set;
  logic [4:0]  int_clr;
  logic [4:0]  int_flags;
  logic [1:0]  pll_set;
  logic [1:0]  pll_clr;
  logic [1:0]  pll_flags;
  logic [2:0]  in_cfg;
  logic [2:0]  out_cfg;
  logic        in_busy;      // Access to IN config in progress
  logic        out_busy;     // Access to OUT config in progress
  logic        in_wr;
  logic        out_wr;

  // Request decode
  assign req    = avs_read || avs_write;
  assign commit = req && !wait_q;
  assign lock   = ctrl_q[`CTRL_FRST] && bus_reset;
  // Writes to locked registers complete but are dropped
  assign wr_ok  = commit && avs_write &&
                  !(lock && lockable(avs_address));

  // Link logic is cleared by disable or by host reset when connected
  assign soft_rst = !ctrl_q[`CTRL_EN] || lock;

  // Waitrequest drops for one cycle after a request appears
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Read data captured in the wait cycle, standing at the commit edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else if (avs_read && wait_q) begin
      case (avs_address)
        `A_CTRL:     rdata_q <= {29'h0, ctrl_q};
        `A_PWR:      rdata_q <= {30'h0, pwr_q};
        `A_PLL_FLAG: rdata_q <= {30'h0, pll_flags};
        `A_INT_STAT: rdata_q <= {27'h0, int_flags};
        `A_INT_MASK: rdata_q <= {27'h0, mask_q};
        `A_IN_CFG:   rdata_q <= {29'h0, in_cfg};
        `A_OUT_CFG:  rdata_q <= {29'h0, out_cfg};
        `A_STATUS:   rdata_q <= {27'h0, state_q, vbus_ok_q};
        default:     rdata_q <= 32'h0;        // Unmapped reads zero
      endcase
    end
  end

  // Control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `CTRL_RST;
    end else if (wr_ok && avs_address == `A_CTRL) begin
      ctrl_q <= avs_writedata[2:0];
    end
  end

  // Power control; all zero shuts both regulators off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_q <= `PWR_RST;
    end else if (wr_ok && avs_address == `A_PWR) begin
      pwr_q <= avs_writedata[1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= 5'h0;
    end else if (wr_ok && avs_address == `A_INT_MASK) begin
      mask_q <= avs_writedata[4:0];
    end
  end

  // Bus power valid needs both the pin and powered detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vbus_ok_q <= 1'b0;
    end else begin
      vbus_ok_q <= vbus_present && (pwr_q != 2'h0);
    end
  end

  // Edge history for bus reset and PLL lock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_reset_q <= 1'b0;
      locked_q    <= 1'b0;
    end else begin
      bus_reset_q <= bus_reset;
      locked_q    <= pll_locked;
    end
  end

  // Interrupt events
  always_comb begin
    int_set              = 5'h0;
    int_set[`INT_BUSRST] = bus_reset && !bus_reset_q;
    int_set[`INT_SUSP]   = suspend_req && ctrl_q[`CTRL_EN];
    int_set[`INT_SETUP]  = setup_evt;
    int_set[`INT_IN0]    = (state_q == usb_ep0_pkg::ST_TX) && tx_done;
    int_set[`INT_OUT0]   = out_ack;
  end

  // Write one to clear; setup, IN0 and OUT0 flags also drop under module reset
  always_comb begin
    int_clr = 5'h0;
    if (wr_ok && avs_address == `A_INT_STAT) begin
      int_clr = avs_writedata[4:0];
    end
    if (soft_rst) begin
      int_clr = int_clr | 5'h1c;
    end
  end

  sticky_flags #(
    .W     (5)
  ) u_int_flags (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (int_set),
    .clr   (int_clr),
    .flags (int_flags)
  );

  // Unlock flag re-sets while unlocked, so a zero readback means stable
  always_comb begin
    pll_set              = 2'h0;
    pll_set[`PLL_UNLOCK] = ctrl_q[`CTRL_PLLEN] && !pll_locked;
    pll_set[`PLL_LOST]   = ctrl_q[`CTRL_PLLEN] && locked_q && !pll_locked;
    pll_clr              = 2'h0;
    if (wr_ok && avs_address == `A_PLL_FLAG) begin
      pll_clr = ~avs_writedata[1:0];  // Writing zero clears
    end
  end

  sticky_flags #(
    .W     (2)
  ) u_pll_flags (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (pll_set),
    .clr   (pll_clr),
    .flags (pll_flags)
  );

  // Interrupt output, level while any unmasked flag is set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_flags & mask_q);
    end
  end

  // Endpoint 0 configuration registers
  assign in_busy  = req && avs_address == `A_IN_CFG;
  assign out_busy = req && avs_address == `A_OUT_CFG;
  assign in_wr    = wr_ok && avs_address == `A_IN_CFG;
  assign out_wr   = wr_ok && avs_address == `A_OUT_CFG;

  ep0_cfg u_in_cfg (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (soft_rst),
    .wr    (in_wr),
    .wdata (avs_writedata[2:0]),
    .busy  (in_busy),
    .setup (setup_evt),
    .cfg   (in_cfg)
  );

  ep0_cfg u_out_cfg (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (soft_rst),
    .wr    (out_wr),
    .wdata (avs_writedata[2:0]),
    .busy  (out_busy),
    .setup (setup_evt),
    .cfg   (out_cfg)
  );

  // Token acceptance only when idle on an enabled module
  assign tok       = tok_valid && tok_ep0 && (state_q == usb_ep0_pkg::ST_IDLE);
  assign setup_evt = tok && tok_kind == usb_ep0_pkg::TOK_SETUP;
  assign out_ack   = tok && tok_kind == usb_ep0_pkg::TOK_OUT && out_cfg[`CFG_EN] &&
                     !out_cfg[`CFG_STALL] && !out_cfg[`CFG_NAK];

  // Next link state
  always_comb begin
    state_d = state_q;
    case (state_q)
      usb_ep0_pkg::ST_OFF: begin
        state_d = usb_ep0_pkg::ST_IDLE;
      end
      usb_ep0_pkg::ST_RESET: begin
        state_d = usb_ep0_pkg::ST_IDLE;
      end
      usb_ep0_pkg::ST_IDLE: begin
        // Transmit only in answer to an accepted IN token
        if (tok && tok_kind == usb_ep0_pkg::TOK_IN && in_cfg[`CFG_EN] &&
            !int_flags[`INT_SETUP] && !in_cfg[`CFG_STALL] && !in_cfg[`CFG_NAK]) begin
          state_d = usb_ep0_pkg::ST_TX;
        end
      end
      usb_ep0_pkg::ST_TX: begin
        if (tx_done) begin
          state_d = usb_ep0_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = usb_ep0_pkg::ST_OFF;  // Illegal code recovers
      end
    endcase
  end

  // State register; disable or connected bus reset overrides all
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= usb_ep0_pkg::ST_OFF;
    end else if (!ctrl_q[`CTRL_EN]) begin
      state_q <= usb_ep0_pkg::ST_OFF;
    end else if (lock) begin
      state_q <= usb_ep0_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Handshake answer, decided from the flags at the token cycle.
  // Sampling once per token keeps a racing flag clear harmless.
  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      hs_valid_q <= 1'b0;
      hs_code_q  <= usb_ep0_pkg::HS_ACK;
    end else if (tok) begin
      case (tok_kind)
        usb_ep0_pkg::TOK_SETUP: begin
          hs_valid_q <= 1'b1;                                  // Setup always taken
          hs_code_q  <= usb_ep0_pkg::HS_ACK;
        end
        usb_ep0_pkg::TOK_IN: begin
          hs_valid_q <= in_cfg[`CFG_EN] &&
                        (int_flags[`INT_SETUP] || in_cfg[`CFG_STALL] || in_cfg[`CFG_NAK]);
          if (int_flags[`INT_SETUP]) begin
            hs_code_q <= usb_ep0_pkg::HS_NAK;
          end else if (in_cfg[`CFG_STALL]) begin
            hs_code_q <= usb_ep0_pkg::HS_STALL;
          end else if (in_cfg[`CFG_NAK]) begin
            hs_code_q <= usb_ep0_pkg::HS_NAK;
          end else begin
            hs_code_q <= usb_ep0_pkg::HS_ACK;  // No handshake, code rests at zero
          end
        end
        usb_ep0_pkg::TOK_OUT: begin
          hs_valid_q <= out_cfg[`CFG_EN];  // Disabled endpoint stays silent
          if (out_cfg[`CFG_STALL]) begin
            hs_code_q <= usb_ep0_pkg::HS_STALL;
          end else if (out_cfg[`CFG_NAK]) begin
            hs_code_q <= usb_ep0_pkg::HS_NAK;
          end else begin
            hs_code_q <= usb_ep0_pkg::HS_ACK;
          end
        end
        default: begin
          hs_valid_q <= 1'b0;
        end
      endcase
    end else begin
      hs_valid_q <= 1'b0;
      hs_code_q  <= usb_ep0_pkg::HS_ACK;  // Code is zero between handshakes
    end
  end

  // Transmit strobe only on the entry into the transmit state
  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      tx_start_q <= 1'b0;
    end else begin
      tx_start_q <= (state_q == usb_ep0_pkg::ST_IDLE) &&
                    (state_d == usb_ep0_pkg::ST_TX);
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq             = irq_q;
  assign hs_valid        = hs_valid_q;
  assign hs_code         = hs_code_q;
  assign tx_start        = tx_start_q;
  assign tx_busy         = state_q[3];                          // One-hot TX bit
  assign pll_en          = ctrl_q[`CTRL_PLLEN];
  assign ldo_en          = pwr_q;

endmodule

// ### bench/usb_ep0_monitor.sv
// Purpose: port-level checker of the EP0 control block
// Assumes: one clock, synchronous active-low reset
// Notes: sees only top-level ports, attached by bind
`timescale 1ns/1ps
module usb_ep0_monitor (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic             avs_waitrequest,
  input  wire logic             tok_valid,
  input  usb_ep0_pkg::tok_kind_t tok_kind,
  input  wire logic             tok_ep0,
  input  wire logic             tx_done,
  input  wire logic             hs_valid,
  input  usb_ep0_pkg::hs_t      hs_code,
  input  wire logic             tx_start,
  input  wire logic             tx_busy
);
  // Single domain, so one clocking and one disable for all
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Every access gets exactly one wait cycle
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");
  wait_low_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // Transmit start enters busy and is a single pulse
  tx_pulse_a: assert property (tx_start |-> tx_busy ##1 !tx_start)
    else $error("transmit start not a busy single pulse");
  // No transmit without an IN token for endpoint 0
  tx_cause_a: assert property (tx_start |-> $past(tok_valid && tok_ep0 && tok_kind == usb_ep0_pkg::TOK_IN))
    else $error("transmit started without an IN token");
  // Handshakes only answer endpoint 0 tokens
  hs_cause_a: assert property (hs_valid |-> $past(tok_valid && tok_ep0))
    else $error("handshake without a token");
  // A handshake after a setup is always an ACK
  setup_ack_a: assert property (hs_valid && $past(tok_kind == usb_ep0_pkg::TOK_SETUP) |-> hs_code == usb_ep0_pkg::HS_ACK)
    else $error("setup not acknowledged");
  // Data and handshake never together
  tx_excl_a: assert property (tx_start |-> !hs_valid)
    else $error("handshake sent with transmit start");
  // Transfer end frees the link on the next cycle
  busy_end_a: assert property (tx_busy && tx_done |=> !tx_busy)
    else $error("busy held after transmit done");
  // Tokens during a transmit are ignored
  tx_quiet_a: assert property (tx_busy && tok_valid |=> !hs_valid && !tx_start)
    else $error("token answered during transmit");
endmodule

// ### bench/usb_host_model.sv
// Purpose: behavioural host on the far side of the link
// Assumes: driven from bench tasks by hierarchical call
// Notes: token lines show inverted values between tokens
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic              clk,
  input  wire logic              tx_busy,
  output logic                   bus_reset,
  output logic                   suspend_req,
  output logic                   tok_valid,
  output usb_ep0_pkg::tok_kind_t tok_kind,
  output logic                   tok_ep0,
  output logic                   tx_done
);
  // Idle link at time zero
  initial begin
    bus_reset = 1'b0;
    suspend_req = 1'b0;
    tok_valid = 1'b0;
    tok_kind = usb_ep0_pkg::TOK_OUT;
    tok_ep0 = 1'b0;
    tx_done = 1'b0;
  end
  // One-cycle token; qualifiers scrambled after so stale values never help
  task automatic tok(input usb_ep0_pkg::tok_kind_t k, input logic e);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_kind <= k;
    tok_ep0 <= e;
    @(posedge clk);
    tok_valid <= 1'b0;
    tok_kind <= usb_ep0_pkg::tok_kind_t'(~k);
    tok_ep0 <= ~e;
  endtask
  // Packet end after n cycles, prompt or slow
  task automatic done(input int n);
    repeat (n) @(posedge clk);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
  endtask
  // Bus reset level and suspend pulse
  task automatic rst(input logic v);
    @(posedge clk);
    bus_reset <= v;
  endtask
  task automatic susp;
    @(posedge clk);
    suspend_req <= 1'b1;
    @(posedge clk);
    suspend_req <= 1'b0;
  endtask
endmodule

// ### bench/usb_ep0_ctrl_test.sv
// Purpose: self-checking bench of the EP0 control block
// Assumes: host model on the link, bench as Avalon master
// Notes: expectations come from the register layout only
`timescale 1ns/1ps
`include "usb_ep0_defines.svh"
module usb_ep0_ctrl_test;
  logic                   clk;
  logic                   rst_n;
  logic [5:0]             avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   irq;
  logic                   bus_reset;
  logic                   suspend_req;
  logic                   tok_valid;
  usb_ep0_pkg::tok_kind_t tok_kind;
  logic                   tok_ep0;
  logic                   tx_done;
  logic                   hs_valid;
  usb_ep0_pkg::hs_t       hs_code;
  logic                   tx_start;
  logic                   tx_busy;
  logic                   vbus_present;
  logic                   pll_locked;
  logic                   pll_en;
  logic [1:0]             ldo_en;
  int                     bad_count;
  int                     n_tests;
  int                     cyc;

  usb_ep0_ctrl uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .bus_reset(bus_reset), .suspend_req(suspend_req),
    .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_ep0(tok_ep0), .tx_done(tx_done),
    .hs_valid(hs_valid), .hs_code(hs_code), .tx_start(tx_start), .tx_busy(tx_busy),
    .vbus_present(vbus_present), .pll_locked(pll_locked), .pll_en(pll_en), .ldo_en(ldo_en));
  usb_host_model host (.clk(clk), .tx_busy(tx_busy), .bus_reset(bus_reset), .suspend_req(suspend_req),
    .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_ep0(tok_ep0), .tx_done(tx_done));

  // 10 MHz clock
  always #50 clk = ~clk;

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Avalon access; request held until waitrequest sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    #1; // Let the commit edge settle before any check
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  // Token, then answer {tx_start, hs_valid, hs_code} in the next cycle
  task automatic hs(input usb_ep0_pkg::tok_kind_t k, input logic e, input logic [3:0] exp);
    host.tok(k, e);
    #1;
    check({28'h0, tx_start, hs_valid, hs_code}, {28'h0, exp});
  endtask

  // Reset values, map, power and PLL polling
  task automatic t_regs;
    rdc(`A_CTRL, 32'h0);
    rdc(6'h3c, 32'h0); // Unmapped reads zero
    wr(`A_CTRL, 32'h1);
    wr(`A_PWR, 32'h3);
    check({30'h0, ldo_en}, 32'h3);
    rdc(`A_STATUS, 32'h9);
    wr(`A_STATUS, 32'h0);
    rdc(`A_STATUS, 32'h9);
    @(posedge clk);
    vbus_present <= 1'b0;
    rdc(`A_STATUS, 32'h8);
    @(posedge clk);
    vbus_present <= 1'b1;
    wr(`A_PWR, 32'h0);
    check({30'h0, ldo_en}, 32'h0);
    wr(`A_PWR, 32'h3);
    wr(`A_CTRL, 32'h5);
    check({31'h0, pll_en}, 32'h1);
    wr(`A_PLL_FLAG, 32'h0);
    rdc(`A_PLL_FLAG, 32'h1);
    @(posedge clk);
    pll_locked <= 1'b1;
    wr(`A_PLL_FLAG, 32'h0);
    rdc(`A_PLL_FLAG, 32'h0);
    $display("test regs done");
  endtask
  // Setup flag, NAK, stall answers, transmit, flags and mask
  task automatic t_setup;
    wr(`A_INT_MASK, 32'h1f);
    wr(`A_IN_CFG, 32'h3);
    wr(`A_OUT_CFG, 32'h1);
    hs(usb_ep0_pkg::TOK_SETUP, 1'b1, 4'h4);
    rdc(`A_INT_STAT, 32'h4);
    check({31'h0, irq}, 32'h1);
    rdc(`A_IN_CFG, 32'h1);
    hs(usb_ep0_pkg::TOK_IN, 1'b1, 4'h5);
    wr(`A_INT_STAT, 32'h4);
    wr(`A_IN_CFG, 32'h3);
    hs(usb_ep0_pkg::TOK_IN, 1'b1, 4'h6);
    hs(usb_ep0_pkg::TOK_OUT, 1'b1, 4'h4);
    hs(usb_ep0_pkg::TOK_IN, 1'b0, 4'h0);
    rdc(`A_INT_STAT, 32'h10);
    wr(`A_INT_STAT, 32'h10);
    wr(`A_IN_CFG, 32'h1);
    hs(usb_ep0_pkg::TOK_IN, 1'b1, 4'h8);
    hs(usb_ep0_pkg::TOK_IN, 1'b1, 4'h0);
    host.done(3);
    @(posedge clk);
    check({31'h0, tx_busy}, 32'h0);
    rdc(`A_INT_STAT, 32'h8);
    wr(`A_INT_MASK, 32'h0);
    repeat (2) @(posedge clk); // Interrupt output is one cycle behind the mask
    check({31'h0, irq}, 32'h0);
    wr(`A_INT_STAT, 32'h8);
    host.susp;
    rdc(`A_INT_STAT, 32'h2);
    wr(`A_INT_STAT, 32'h1f);
    $display("test setup done");
  endtask
  // Setup arriving during a config write: write lands, clear follows
  task automatic t_hold;
    fork
      wr(`A_IN_CFG, 32'h3);
      host.tok(usb_ep0_pkg::TOK_SETUP, 1'b1);
    join
    rdc(`A_IN_CFG, 32'h1);
    wr(`A_INT_STAT, 32'h1f);
    $display("test hold done");
  endtask
  // Bus reset with function reset connected
  task automatic t_busrst;
    wr(`A_CTRL, 32'h3);
    wr(`A_IN_CFG, 32'h3);
    host.rst(1'b1);
    wr(`A_CTRL, 32'h7);
    rdc(`A_CTRL, 32'h3);
    wr(`A_IN_CFG, 32'h3);
    rdc(`A_IN_CFG, 32'h0);
    rdc(`A_STATUS, 32'h5);
    hs(usb_ep0_pkg::TOK_SETUP, 1'b1, 4'h0);
    host.rst(1'b0);
    rdc(`A_INT_STAT, 32'h1);
    wr(`A_CTRL, 32'h1);
    rdc(`A_CTRL, 32'h1);
    wr(`A_INT_STAT, 32'h1f);
    $display("test bus reset done");
  endtask
  // Enable clear aborts a transmit; module comes back
  task automatic t_modrst;
    wr(`A_IN_CFG, 32'h1);
    hs(usb_ep0_pkg::TOK_IN, 1'b1, 4'h8);
    wr(`A_CTRL, 32'h0);
    repeat (2) @(posedge clk); // State follows the enable one cycle later
    check({31'h0, tx_busy}, 32'h0);
    rdc(`A_STATUS, 32'h3);
    rdc(`A_IN_CFG, 32'h0);
    wr(`A_CTRL, 32'h1);
    wr(`A_IN_CFG, 32'h1);
    hs(usb_ep0_pkg::TOK_IN, 1'b1, 4'h8);
    host.done(1);
    $display("test module reset done");
  endtask

  // Verdict and end of run
  task complete_run;
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      complete_run;
    end
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 6'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    vbus_present = 1'b1;
    pll_locked = 1'b0;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_setup;
    t_hold;
    t_busrst;
    t_modrst;
    complete_run;
  end
endmodule

bind usb_ep0_ctrl usb_ep0_monitor mon (.clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_ep0(tok_ep0),
  .tx_done(tx_done), .hs_valid(hs_valid), .hs_code(hs_code), .tx_start(tx_start), .tx_busy(tx_busy));
